// *** shared/cycle_sync_map.vh ***
`ifndef CYCLE_SYNC_MAP_VH
`define CYCLE_SYNC_MAP_VH
// register byte offsets
`define A_OUT_MODE 8'h00
`define A_OUT_CYCLE 8'h04
`define A_OUT_SHIFT 8'h08
`define A_OUT_SUPP 8'h0c
`define A_OUT_MINCYC 8'h10
`define A_OUT_CALC 8'h14
`define A_OUT_MINDLY 8'h18
`define A_OUT_CMD 8'h1c
`define A_OUT_MAXDLY 8'h20
`define A_OUT_MISSED 8'h24
`define A_OUT_OVERRUN 8'h28
`define A_OUT_SHORT 8'h2c
`define A_OUT_LATE 8'h30
`define A_IN_ENTRIES 8'h40
`define A_IN_MODE 8'h44
`define A_IN_CYCLE 8'h48
`define A_IN_SHIFT 8'h4c
`define A_IN_SUPP 8'h50
`define A_IN_MINCYC 8'h54
`define A_IN_CALC 8'h58
`define A_IN_MINDLY 8'h5c
`define A_IN_CMD 8'h60
`define A_IN_MAXDLY 8'h64
`define A_IN_MISSED 8'h68
`define A_IN_OVERRUN 8'h6c
`define A_IN_SHORT 8'h70
`define A_IN_LATE 8'h74
`define A_IRQ_STATUS 8'h78
`define A_IRQ_MASK 8'h7c
// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// sync mode codes
`define MODE_FREE 16'h0000
`define MODE_SM 16'h0001
`define MODE_P0 16'h0002
`define MODE_P1 16'h0003
`define MODE_OUT_SM 16'h0022
// supported-modes bitmap fields
`define SUP_FREE 0
`define SUP_SM 1
`define SUP_DC_HI 3
`define SUP_DC_LO 2
`define SUP_DC_VAL 2'b01
`define SUP_SHIFT_HI 5
`define SUP_SHIFT_LO 4
`define SHIFT_LOCAL 2'b01
`define SHIFT_P1 2'b10
`define SUP_DYN 14
// reset values
`define RST_CYCLE 32'h0003d090
`define RST_TIME 32'h00000384
`define RST_ZERO32 32'h00000000
`define RST_ZERO16 16'h0000
`define RST_ENTRIES 8'h20
`define RST_SUPPORTED 16'h0001
// measurement commands
`define CMD_STOP 16'h0000
`define CMD_START 16'h0001
// timing
`define CLK_PERIOD_NS 32'd8
`define SAT16 16'hffff
`define SAT32 32'hffffffff
// synchronised input vector positions
`define S_P0 0
`define S_P1 1
`define S_OSM 2
`define S_ISM 3
`define S_OP 4
`define S_OAPP 5
`define S_ISAMP 6
`define S_IRDY 7
`endif

// *** verilog/cycle_sync_timing_monitor.v ***
// Overview of operation
// - input mode: free, sm, pulse0, pulse1, 34
// - command 1 starts measuring, 0 stops
// - measuring overwrites timing entries with maxima
// - new measurement clears earlier measured values
// - output max delay: pulse one to outputs
// - count missed channel events, state_a, dc
// - count overrun cycles in state_a state
// - count too-short pulse gaps in dc
// - late flag: outputs late last dc cycle
// - input shift: pulse zero to sampling
// - input calc-copy: sampling to availability
// - input max delay: pulse one to sampling
// - supported-modes bitmap layout and meaning
// - output mode: free, sm, pulse0, pulse1
// - output shift: pulse zero to outputs
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "cycle_sync_map.vh"
module cycle_sync_timing_monitor #(
   parameter [15:0] OUT_SUPPORTED = `RST_SUPPORTED,
   parameter [15:0] IN_SUPPORTED = `RST_SUPPORTED
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] awaddr,
   input wire awvalid,
   output wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [7:0] araddr,
   input wire arvalid,
   output wire arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   input wire dc_pulse_zero,
   input wire dc_pulse_one,
   input wire output_sync_channel,
   input wire input_sync_channel,
   input wire state_a,
   input wire outputs_applied,
   input wire inputs_sampled,
   input wire inputs_ready,
   output wire irq
);

   function [15:0] sat_inc;
      input [15:0] v;
      begin
         sat_inc = (v == `SAT16) ? v : v + 16'h0001;
      end
   endfunction

   function [31:0] sat_add;
      input [31:0] v;
      begin
         sat_add = (v > `SAT32 - `CLK_PERIOD_NS) ? `SAT32 : v + `CLK_PERIOD_NS;
      end
   endfunction

   function [31:0] max32;
      input [31:0] a;
      input [31:0] b;
      begin
         max32 = (a > b) ? a : b;
      end
   endfunction

   function is_dc;
      input [15:0] m;
      begin
         is_dc = (m == `MODE_P0) || (m == `MODE_P1);
      end
   endfunction

   // a mode is taken only if the side's bitmap supports it
   function mode_ok;
      input [15:0] m;
      input [15:0] sup;
      input in_side;
      begin
         case (m)
            `MODE_FREE: mode_ok = sup[`SUP_FREE];
            `MODE_SM: mode_ok = sup[`SUP_SM];
            `MODE_P0, `MODE_P1: mode_ok = (sup[`SUP_DC_HI:`SUP_DC_LO] == `SUP_DC_VAL);
            `MODE_OUT_SM: mode_ok = in_side & sup[`SUP_SM];
            default: mode_ok = 1'b0;
         endcase
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   // input synchroniser and edge detect
   reg [7:0] s1_q, s2_q, s3_q;
   wire [7:0] pin_v = {inputs_ready, inputs_sampled, outputs_applied, state_a,
      input_sync_channel, output_sync_channel, dc_pulse_one, dc_pulse_zero};
   wire [7:0] rise = s2_q & ~s3_q;
   wire op = s2_q[`S_OP];

   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
         s3_q <= 8'h00;
      end else begin
         s1_q <= pin_v;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // register state
   reg [15:0] out_mode_q, in_mode_q, out_cmd_q, in_cmd_q;
   reg [31:0] out_cycle_q, in_cycle_q, out_shift_q, in_shift_q;
   reg [31:0] out_mincyc_q, in_mincyc_q, out_calc_q, in_calc_q;
   reg [31:0] out_maxdly_q, in_maxdly_q;
   reg [15:0] out_missed_q, in_missed_q, out_overrun_q, in_overrun_q;
   reg [15:0] out_short_q, in_short_q;
   reg out_late_q, in_late_q;
   reg [7:0] irq_status_q, irq_mask_q;
   // timers in ns
   reg [31:0] t0_q, t1_q, ts_q, out_tc_q, in_tc_q;
   reg out_busy_q, in_busy_q, out_seen_q, in_seen_q;

   // axi-lite write channel
   reg aw_have_q, w_have_q;
   reg [7:0] waddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   assign awready = ~aw_have_q;
   assign wready = ~w_have_q;
   wire wr_en = aw_have_q & w_have_q & ~bvalid;
   wire [31:0] wr_val = merge(32'h00000000, wdata_q, wstrb_q);
   assign arready = ~rvalid;

   wire out_dc = is_dc(out_mode_q);
   wire in_dc = is_dc(in_mode_q);
   wire out_meas = (out_cmd_q == `CMD_START);
   wire in_meas = (in_cmd_q == `CMD_START);
   reg out_start, in_start;

   // cycle start per side
   always @* begin
      case (out_mode_q)
         `MODE_SM: out_start = rise[`S_OSM];
         `MODE_P0: out_start = rise[`S_P0];
         `MODE_P1: out_start = rise[`S_P1];
         default: out_start = (out_tc_q >= out_cycle_q);
      endcase
      case (in_mode_q)
         `MODE_SM: in_start = rise[`S_ISM];
         `MODE_OUT_SM: in_start = rise[`S_OSM];
         `MODE_P0: in_start = rise[`S_P0];
         `MODE_P1: in_start = rise[`S_P1];
         default: in_start = (in_tc_q >= in_cycle_q);
      endcase
   end

   wire ev_out_missed = op & out_dc & rise[`S_P0] & ~out_seen_q & ~rise[`S_OSM];
   wire ev_in_missed = op & in_dc & rise[`S_P0] & ~in_seen_q & ~rise[`S_ISM];
   wire ev_out_over = op & out_start & out_busy_q;
   wire ev_in_over = op & in_start & in_busy_q;
   wire ev_out_short = out_dc & rise[`S_P1] & (t0_q < out_calc_q);
   wire ev_in_short = in_dc & rise[`S_P1] & (t0_q < in_calc_q);
   wire ev_out_late = out_dc & rise[`S_OAPP] & (t0_q > out_shift_q);
   wire ev_in_late = in_dc & rise[`S_ISAMP] & (t0_q > in_shift_q);
   wire [7:0] events = {ev_in_late, ev_in_short, ev_in_over, ev_in_missed,
      ev_out_late, ev_out_short, ev_out_over, ev_out_missed};
   assign irq = |(irq_status_q & irq_mask_q);

   wire wr_out_cmd = wr_en & (waddr_q == `A_OUT_CMD);
   wire wr_in_cmd = wr_en & (waddr_q == `A_IN_CMD);
   wire [31:0] out_cmd_m = merge({16'h0000, out_cmd_q}, wdata_q, wstrb_q);
   wire [31:0] in_cmd_m = merge({16'h0000, in_cmd_q}, wdata_q, wstrb_q);
   wire [31:0] mask_m = merge({24'h000000, irq_mask_q}, wdata_q, wstrb_q);
   wire [15:0] new_out_cmd = out_cmd_m[15:0];
   wire [15:0] new_in_cmd = in_cmd_m[15:0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= `RST_ZERO32;
         wstrb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else begin
         if (awvalid & ~aw_have_q) begin
            aw_have_q <= 1'b1;
            waddr_q <= {awaddr[7:2], 2'b00};
         end else if (wr_en) begin
            aw_have_q <= 1'b0;
         end
         if (wvalid & ~w_have_q) begin
            w_have_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end else if (wr_en) begin
            w_have_q <= 1'b0;
         end
         if (wr_en) begin
            bvalid <= 1'b1;
            bresp <= (waddr_q > `A_IRQ_MASK) ? `RESP_SLVERR : `RESP_OKAY;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // timers, status and measurement
   always @(posedge aclk) begin
      if (!aresetn) begin
         t0_q <= `RST_ZERO32;
         t1_q <= `RST_ZERO32;
         ts_q <= `RST_ZERO32;
         out_tc_q <= `RST_ZERO32;
         in_tc_q <= `RST_ZERO32;
         out_busy_q <= 1'b0;
         in_busy_q <= 1'b0;
         out_seen_q <= 1'b0;
         in_seen_q <= 1'b0;
         out_mode_q <= `MODE_FREE;
         in_mode_q <= `MODE_FREE;
         out_cycle_q <= `RST_CYCLE;
         in_cycle_q <= `RST_CYCLE;
         out_cmd_q <= `CMD_STOP;
         in_cmd_q <= `CMD_STOP;
         out_shift_q <= `RST_TIME;
         in_shift_q <= `RST_TIME;
         out_mincyc_q <= `RST_CYCLE;
         in_mincyc_q <= `RST_CYCLE;
         out_calc_q <= `RST_ZERO32;
         in_calc_q <= `RST_ZERO32;
         out_maxdly_q <= `RST_TIME;
         in_maxdly_q <= `RST_TIME;
         out_missed_q <= `RST_ZERO16;
         in_missed_q <= `RST_ZERO16;
         out_overrun_q <= `RST_ZERO16;
         in_overrun_q <= `RST_ZERO16;
         out_short_q <= `RST_ZERO16;
         in_short_q <= `RST_ZERO16;
         out_late_q <= 1'b0;
         in_late_q <= 1'b0;
         irq_status_q <= 8'h00;
         irq_mask_q <= 8'h00;
      end else begin
         t0_q <= rise[`S_P0] ? `RST_ZERO32 : sat_add(t0_q);
         t1_q <= rise[`S_P1] ? `RST_ZERO32 : sat_add(t1_q);
         ts_q <= rise[`S_ISAMP] ? `RST_ZERO32 : sat_add(ts_q);
         out_tc_q <= out_start ? `RST_ZERO32 : sat_add(out_tc_q);
         in_tc_q <= in_start ? `RST_ZERO32 : sat_add(in_tc_q);
         if (out_start) out_busy_q <= 1'b1;
         else if (rise[`S_OAPP]) out_busy_q <= 1'b0;
         if (in_start) in_busy_q <= 1'b1;
         else if (rise[`S_IRDY]) in_busy_q <= 1'b0;
         if (rise[`S_P0]) out_seen_q <= 1'b0;
         else if (rise[`S_OSM]) out_seen_q <= 1'b1;
         if (rise[`S_P0]) in_seen_q <= 1'b0;
         else if (rise[`S_ISM]) in_seen_q <= 1'b1;
         if (ev_out_missed) out_missed_q <= sat_inc(out_missed_q);
         if (ev_in_missed) in_missed_q <= sat_inc(in_missed_q);
         if (ev_out_over) out_overrun_q <= sat_inc(out_overrun_q);
         if (ev_in_over) in_overrun_q <= sat_inc(in_overrun_q);
         if (ev_out_short) out_short_q <= sat_inc(out_short_q);
         if (ev_in_short) in_short_q <= sat_inc(in_short_q);
         if (out_dc & rise[`S_OAPP]) out_late_q <= ev_out_late;
         if (in_dc & rise[`S_ISAMP]) in_late_q <= ev_in_late;
         // measurement, outputs
         if (wr_out_cmd & (new_out_cmd == `CMD_START)) begin
            out_shift_q <= `RST_ZERO32;
            out_mincyc_q <= `RST_ZERO32;
            out_calc_q <= `RST_ZERO32;
            out_maxdly_q <= `RST_ZERO32;
         end else if (out_meas) begin
            if (rise[`S_OAPP]) begin
               out_shift_q <= max32(out_shift_q, t0_q);
               out_maxdly_q <= max32(out_maxdly_q, t1_q);
            end
            if (out_start) out_mincyc_q <= max32(out_mincyc_q, out_tc_q);
            if (rise[`S_P1]) out_calc_q <= max32(out_calc_q, t0_q);
         end
         // measurement, inputs
         if (wr_in_cmd & (new_in_cmd == `CMD_START)) begin
            in_shift_q <= `RST_ZERO32;
            in_mincyc_q <= `RST_ZERO32;
            in_calc_q <= `RST_ZERO32;
            in_maxdly_q <= `RST_ZERO32;
         end else if (in_meas) begin
            if (rise[`S_ISAMP]) begin
               in_shift_q <= max32(in_shift_q, t0_q);
               in_maxdly_q <= max32(in_maxdly_q, t1_q);
            end
            if (in_start) in_mincyc_q <= max32(in_mincyc_q, in_tc_q);
            if (rise[`S_IRDY]) in_calc_q <= max32(in_calc_q, ts_q);
         end
         if (wr_out_cmd) out_cmd_q <= new_out_cmd;
         if (wr_in_cmd) in_cmd_q <= new_in_cmd;
         if (wr_en) begin
            case (waddr_q)
               `A_OUT_MODE: if (mode_ok(wr_val[15:0], OUT_SUPPORTED, 1'b0)) out_mode_q <= wr_val[15:0];
               `A_IN_MODE: if (mode_ok(wr_val[15:0], IN_SUPPORTED, 1'b1)) in_mode_q <= wr_val[15:0];
               `A_OUT_CYCLE: out_cycle_q <= merge(out_cycle_q, wdata_q, wstrb_q);
               `A_IN_CYCLE: in_cycle_q <= merge(in_cycle_q, wdata_q, wstrb_q);
               `A_IRQ_MASK: irq_mask_q <= mask_m[7:0];
               default: ;
            endcase
         end
         // set wins over write-one-to-clear
         if (wr_en & (waddr_q == `A_IRQ_STATUS)) irq_status_q <= (irq_status_q & ~wr_val[7:0]) | events;
         else irq_status_q <= irq_status_q | events;
      end
   end

   // read channel
   reg [31:0] rd_mux;
   always @* begin
      case (araddr & 8'hfc)
         `A_OUT_MODE: rd_mux = {16'h0000, out_mode_q};
         `A_OUT_CYCLE: rd_mux = out_cycle_q;
         `A_OUT_SHIFT: rd_mux = out_shift_q;
         `A_OUT_SUPP: rd_mux = {16'h0000, OUT_SUPPORTED};
         `A_OUT_MINCYC: rd_mux = out_mincyc_q;
         `A_OUT_CALC: rd_mux = out_calc_q;
         `A_OUT_MINDLY: rd_mux = `RST_TIME;
         `A_OUT_CMD: rd_mux = {16'h0000, out_cmd_q};
         `A_OUT_MAXDLY: rd_mux = out_maxdly_q;
         `A_OUT_MISSED: rd_mux = {16'h0000, out_missed_q};
         `A_OUT_OVERRUN: rd_mux = {16'h0000, out_overrun_q};
         `A_OUT_SHORT: rd_mux = {16'h0000, out_short_q};
         `A_OUT_LATE: rd_mux = {31'h00000000, out_late_q};
         `A_IN_ENTRIES: rd_mux = {24'h000000, `RST_ENTRIES};
         `A_IN_MODE: rd_mux = {16'h0000, in_mode_q};
         `A_IN_CYCLE: rd_mux = in_cycle_q;
         `A_IN_SHIFT: rd_mux = in_shift_q;
         `A_IN_SUPP: rd_mux = {16'h0000, IN_SUPPORTED};
         `A_IN_MINCYC: rd_mux = in_mincyc_q;
         `A_IN_CALC: rd_mux = in_calc_q;
         `A_IN_MINDLY: rd_mux = `RST_TIME;
         `A_IN_CMD: rd_mux = {16'h0000, in_cmd_q};
         `A_IN_MAXDLY: rd_mux = in_maxdly_q;
         `A_IN_MISSED: rd_mux = {16'h0000, in_missed_q};
         `A_IN_OVERRUN: rd_mux = {16'h0000, in_overrun_q};
         `A_IN_SHORT: rd_mux = {16'h0000, in_short_q};
         `A_IN_LATE: rd_mux = {31'h00000000, in_late_q};
         `A_IRQ_STATUS: rd_mux = {24'h000000, irq_status_q};
         `A_IRQ_MASK: rd_mux = {24'h000000, irq_mask_q};
         default: rd_mux = `RST_ZERO32;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= `RST_ZERO32;
         rresp <= `RESP_OKAY;
      end else if (arvalid & ~rvalid) begin
         rvalid <= 1'b1;
         rdata <= rd_mux;
         rresp <= (araddr > `A_IRQ_MASK + 8'h03) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

endmodule // cycle_sync_timing_monitor

// *** verif/cycle_sync_timing_monitor_sva.sv ***
`timescale 1ns/1ns
`include "cycle_sync_map.vh"
module cycle_sync_checker #(
   parameter [15:0] OUT_SUPPORTED = `RST_SUPPORTED,
   parameter [15:0] IN_SUPPORTED = `RST_SUPPORTED
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] araddr,
   input wire awvalid,
   input wire awready,
   input wire wvalid,
   input wire wready,
   input wire [1:0] bresp,
   input wire bvalid,
   input wire bready,
   input wire arvalid,
   input wire arready,
   input wire [31:0] rdata,
   input wire [1:0] rresp,
   input wire rvalid,
   input wire rready,
   input wire irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_rd;
      arvalid && arready;
   endsequence
   sequence s_wr;
      awvalid && awready && wvalid && wready;
   endsequence
   property p_reset_idle;
      @(posedge aclk) disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !irq && arready;
   endproperty
   a_write_answer: assert property (s_wr |=> !awready && !wready ##1 bvalid)
      else $error("write not answered");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   a_read_answer: assert property (s_rd |=> rvalid)
      else $error("read not answered");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer dropped");
   a_read_block: assert property (rvalid |-> !arready)
      else $error("read taken while busy");
   a_addr_hold: assert property (awvalid && awready && !wvalid |=> !awready)
      else $error("address not held");
   a_unmapped_read: assert property (s_rd ##0 araddr[7] |=> rdata == 32'h0 && rresp == `RESP_SLVERR)
      else $error("unmapped read answered");
   a_supp_map: assert property (s_rd ##0 araddr == `A_IN_SUPP |=> rdata == {16'h0, IN_SUPPORTED})
      else $error("supported bitmap wrong");
   a_entry_count: assert property (s_rd ##0 araddr == `A_IN_ENTRIES |=> rdata == {24'h0, `RST_ENTRIES})
      else $error("entry count wrong");
   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs busy after reset");
endmodule // cycle_sync_checker
bind cycle_sync_timing_monitor cycle_sync_checker #(.OUT_SUPPORTED(OUT_SUPPORTED), .IN_SUPPORTED(IN_SUPPORTED)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .araddr(araddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
   .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));

// *** verif/sync_event_source.sv ***
`timescale 1ns/1ns
module sync_event_source (
   input wire aclk,
   output wire dc_pulse_zero,
   output wire dc_pulse_one,
   output wire output_sync_channel,
   output wire input_sync_channel,
   output wire outputs_applied,
   output wire inputs_sampled,
   output wire inputs_ready
);
   reg [6:0] pins_q;
   initial pins_q = 7'h00;
   assign {inputs_ready, inputs_sampled, outputs_applied, input_sync_channel, output_sync_channel, dc_pulse_one,
      dc_pulse_zero} = pins_q;
   // pin high three clocks, then low three clocks
   task fire(input integer idx);
      begin
         @(posedge aclk);
         pins_q[idx] <= 1'b1;
         repeat (3) @(posedge aclk);
         pins_q[idx] <= 1'b0;
         repeat (3) @(posedge aclk);
      end
   endtask
endmodule // sync_event_source

// *** verif/tb_cycle_sync_timing_monitor.sv ***
`timescale 1ns/1ns
`include "cycle_sync_map.vh"
module tb_cycle_sync_timing_monitor;
   localparam [15:0] SUPP = 16'h4007;
   localparam [1:0] OK = `RESP_OKAY;
   localparam [1:0] ER = `RESP_SLVERR;
   reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, state_a;
   reg [7:0] awaddr, araddr;
   reg [31:0] wdata, rd, c0;
   reg [3:0] wstrb, ws;
   reg [1:0] rs;
   wire awready, wready, bvalid, arready, rvalid, irq, p0, p1, osm, ism, oapp, isamp, irdy;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer n_errors, num_checks, cycles, nrows, i;
   reg tw [0:63];
   reg [7:0] ta [0:63];
   reg [31:0] td [0:63];
   reg [31:0] te [0:63];
   reg [1:0] tr [0:63];
   reg [7:0] ca [0:3];
   reg [31:0] cb [0:3];
   reg [15:0] mc [0:4];
   cycle_sync_timing_monitor #(.OUT_SUPPORTED(SUPP), .IN_SUPPORTED(SUPP)) DUT (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .dc_pulse_zero(p0), .dc_pulse_one(p1), .output_sync_channel(osm),
      .input_sync_channel(ism), .state_a(state_a), .outputs_applied(oapp), .inputs_sampled(isamp),
      .inputs_ready(irdy), .irq(irq));
   sync_event_source src (.aclk(aclk), .dc_pulse_zero(p0), .dc_pulse_one(p1), .output_sync_channel(osm),
      .input_sync_channel(ism), .outputs_applied(oapp), .inputs_sampled(isamp), .inputs_ready(irdy));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task end_of_test;
      begin
         $display("checks %0d errors %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (cycles == 10000) begin
         n_errors = n_errors + 1;
         $display("[ERR] %0t timeout", $time);
         end_of_test;
      end
   end
   task check(input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task axi_write(input [7:0] a, input [31:0] d, output [1:0] r);
      reg aw_ok, w_ok, got;
      begin
         @(posedge aclk);
         awaddr <= a; wdata <= d; wstrb <= ws; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
         aw_ok = 1'b0; w_ok = 1'b0; got = 1'b0;
         while (!got) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
            if (!w_ok && wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
            if (bvalid === 1'b1) begin r = bresp; bready <= 1'b0; got = 1'b1; end
         end
      end
   endtask
   task axi_read(input [7:0] a, output [31:0] d, output [1:0] r);
      reg got;
      begin
         @(posedge aclk);
         araddr <= a; arvalid <= 1'b1; rready <= 1'b1; got = 1'b0;
         while (!got) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin d = rdata; r = rresp; rready <= 1'b0; got = 1'b1; end
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      axi_write(a, d, rs);
   endtask
   task rchk(input [7:0] a, input [31:0] e);
      begin axi_read(a, rd, rs); check(rd, e); end
   endtask
   task row(input w, input [7:0] a, input [31:0] d, input [31:0] e, input [1:0] r);
      begin tw[nrows] = w; ta[nrows] = a; td[nrows] = d; te[nrows] = e; tr[nrows] = r; nrows = nrows + 1; end
   endtask
   task snap;
      for (i = 0; i < 4; i = i + 1) axi_read(ca[i], cb[i], rs);
   endtask
   task delta(input [31:0] n);
      for (i = 0; i < 4; i = i + 1) rchk(ca[i], cb[i] + n);
   endtask
   initial begin
      n_errors = 0; num_checks = 0; cycles = 0; nrows = 0; aresetn = 1'b0; state_a = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
      ws = 4'hf;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      ca[0] = `A_OUT_MISSED; ca[1] = `A_OUT_OVERRUN; ca[2] = `A_IN_MISSED; ca[3] = `A_IN_OVERRUN;
      mc[0] = `MODE_FREE; mc[1] = `MODE_SM; mc[2] = `MODE_P0; mc[3] = `MODE_P1; mc[4] = `MODE_OUT_SM;
      row(0, `A_OUT_MAXDLY, 0, `RST_TIME, OK); row(0, `A_OUT_MINDLY, 0, `RST_TIME, OK);
      row(0, `A_OUT_CMD, 0, 0, OK); row(0, `A_OUT_LATE, 0, 0, OK); row(0, `A_IN_ENTRIES, 0, 32'h20, OK);
      row(0, `A_IN_MODE, 0, 0, OK); row(0, `A_IN_CYCLE, 0, `RST_CYCLE, OK); row(0, `A_IN_SHIFT, 0, `RST_TIME, OK);
      row(0, `A_IN_SUPP, 0, SUPP, OK); row(0, `A_IN_MINCYC, 0, `RST_CYCLE, OK); row(0, `A_IN_CALC, 0, 0, OK);
      row(0, `A_IN_MAXDLY, 0, `RST_TIME, OK); row(0, `A_IN_SHORT, 0, 0, OK); row(0, `A_IN_LATE, 0, 0, OK);
      row(1, `A_IN_SHIFT, 5, 0, OK); row(0, `A_IN_SHIFT, 0, `RST_TIME, OK);
      row(1, 8'h80, 1, 0, ER); row(0, 8'h80, 0, 0, ER); row(1, `A_IN_CYCLE, 32'h1234, 0, OK);
      row(0, `A_IN_CYCLE, 0, 32'h1234, OK); row(0, `A_IRQ_STATUS, 0, 0, OK); row(0, `A_IRQ_MASK, 0, 0, OK);
      for (i = 0; i < 5; i = i + 1) begin
         row(1, `A_IN_MODE, mc[i], 0, OK); row(0, `A_IN_MODE, 0, mc[i], OK);
         if (i < 4) begin row(1, `A_OUT_MODE, mc[i], 0, OK); row(0, `A_OUT_MODE, 0, mc[i], OK); end
      end
      row(1, `A_IN_MODE, 16'h0005, 0, OK); row(0, `A_IN_MODE, 0, `MODE_OUT_SM, OK);
      row(1, `A_OUT_MODE, `MODE_OUT_SM, 0, OK);
      row(0, `A_OUT_MODE, 0, `MODE_P1, OK);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      check({bvalid, rvalid, irq}, 0);
      for (i = 0; i < nrows; i = i + 1) begin
         if (tw[i]) begin
            axi_write(ta[i], td[i], rs);
            check(rs, tr[i]);
         end else begin
            axi_read(ta[i], rd, rs);
            check(rd, te[i]);
            check(rs, tr[i]);
         end
      end
      $display("table done");
      wr(`A_OUT_MODE, `MODE_P0);
      ws = 4'h1;
      wr(`A_IN_MODE, 32'hffff0002);
      ws = 4'hf;
      rchk(`A_IN_MODE, `MODE_P0);
      wr(`A_IRQ_MASK, 32'h01);
      state_a <= 1'b1;
      src.fire(0); src.fire(2); src.fire(3); src.fire(4); src.fire(6);
      wr(`A_IRQ_STATUS, 32'hff); snap;
      src.fire(0);
      delta(0);
      rchk(`A_IRQ_STATUS, 0);
      src.fire(0);
      delta(1);
      rchk(`A_IRQ_STATUS, 32'h33);
      check(irq, 1);
      wr(`A_IRQ_STATUS, 32'h01);
      check(irq, 0);
      rchk(`A_IRQ_STATUS, 32'h32);
      wr(`A_IRQ_MASK, 32'h02);
      check(irq, 1);
      wr(`A_IRQ_STATUS, 32'hff);
      check(irq, 0);
      state_a <= 1'b0;
      snap; src.fire(0);
      delta(0);
      $display("counters done");
      src.fire(0); repeat (140) @(posedge aclk); src.fire(4); src.fire(5);
      rchk(`A_OUT_LATE, 1);
      rchk(`A_IN_LATE, 1);
      src.fire(0); src.fire(4); src.fire(5); src.fire(1);
      rchk(`A_OUT_LATE, 0);
      rchk(`A_IN_LATE, 0);
      rchk(`A_OUT_SHORT, 0);
      $display("late done");
      wr(`A_OUT_CMD, `CMD_START);
      rchk(`A_OUT_SHIFT, 0);
      rchk(`A_OUT_MAXDLY, 0);
      src.fire(0); repeat (20) @(posedge aclk); src.fire(4);
      src.fire(1);
      axi_read(`A_OUT_SHIFT, c0, rs);
      check(c0 >= 200 && c0 <= 240, 1);
      wr(`A_OUT_CMD, `CMD_STOP);
      src.fire(0); repeat (60) @(posedge aclk); src.fire(4);
      rchk(`A_OUT_SHIFT, c0);
      src.fire(0);
      src.fire(1);
      rchk(`A_OUT_SHORT, 1);
      rchk(`A_IN_SHORT, 0);
      wr(`A_OUT_CMD, `CMD_START);
      rchk(`A_OUT_SHIFT, 0);
      wr(`A_IN_CMD, `CMD_START);
      rchk(`A_IN_SHIFT, 0);
      $display("measure done");
      @(posedge aclk) aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      check({bvalid, rvalid, irq}, 0);
      rchk(`A_IN_MODE, 0);
      rchk(`A_OUT_SHIFT, `RST_TIME);
      rchk(`A_OUT_CMD, 0);
      $display("reset done");
      end_of_test;
   end
endmodule // tb_cycle_sync_timing_monitor
